// File: rtl/dpc_cfg.svh
// Constants for the DDR pin capture block
`ifndef DPC_CFG_SVH
`define DPC_CFG_SVH

`define DPC_ADDR_W 21
`define DPC_BANK_W 3
`define DPC_DQ_W 36
`define DPC_HALF_W 18
`define DPC_X9_W 9
`define DPC_CMD_BUS_W 27
`define DPC_CMD_CS_POS 26
`define DPC_CMD_WE_POS 25
`define DPC_CMD_REF_POS 24
`define DPC_CMD_BANK_LSB 21
`define DPC_CMD_IDLE 27'h7000000

`define DPC_ORG_CODE_X9 2'h0
`define DPC_ORG_CODE_X18 2'h1
`define DPC_ORG_CODE_X36 2'h2

`define DPC_BURST_BEATS 4'h2
`define DPC_FIFO_DEPTH 16
`define DPC_FIFO_W 36

`define DPC_CLK_NS 50
`define DPC_QK_HALF_NS 200
`define DPC_QK_HALF_CYC (`DPC_QK_HALF_NS / `DPC_CLK_NS)

`endif

// File: rtl/dpc_fifo.sv
// Write data FIFO with valid and ready on both sides
`timescale 1ns/100ps

module dpc_fifo #(
	parameter int W = 36,
	parameter int D = 16
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [W-1:0] in_data_i,
	// Drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o
);
	localparam int AW = $clog2(D);

	typedef struct packed {
		logic [AW-1:0] wr_ptr;
		logic [AW-1:0] rd_ptr;
		logic [AW:0] count;
	} dpc_fifo_state_t;

	dpc_fifo_state_t s_reg;
	dpc_fifo_state_t s_next;
	logic [W-1:0] mem_reg [D];
	logic push;
	logic pop;

	assign in_ready_o = (s_reg.count != AW'(0) + (AW+1)'(D));
	assign out_valid_o = (s_reg.count != '0);
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;
	assign out_data_o = mem_reg[s_reg.rd_ptr];

	always_comb begin
		s_next = s_reg;
		if (push) begin
			s_next.wr_ptr = s_reg.wr_ptr + AW'(1);
		end
		if (pop) begin
			s_next.rd_ptr = s_reg.rd_ptr + AW'(1);
		end
		if (push && !pop) begin
			s_next.count = s_reg.count + (AW+1)'(1);
		end else if (pop && !push) begin
			s_next.count = s_reg.count - (AW+1)'(1);
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_reg[s_reg.wr_ptr] <= in_data_i;
		end
	end

endmodule // dpc_fifo

// File: rtl/dpc_pin_capture.sv
// Pin capture and clocking interface of an eight-bank DDR DRAM
// Overview of operation
// R1: Commands and addresses are latched only at the rising input clock edge.
// R2: Low chip select enables the command decoder; high disables it.
// R3: With decoder disabled new commands are ignored; running operations finish.
// R4: Twenty-one address inputs carry row and column, sampled at rising clock.
// R5: Mode register set takes register settings from the address inputs.
// R6: Each command goes only to the bank named by bank select.
// R7: Write data is sampled on both edges of the write data clock.
// R8: Read data, up to 36 bits, driven on both edges of output clock.
// R9: In x36, lower half uses first write clock, upper half the second.
// R10: In x9 and x18, all data bits use the single write clock.
// R11: Controller always drives every write data clock pair.
// R12: Beats sampled with mask high are discarded; x36 uses second clock.
// R13: Read data valid is edge-aligned and high exactly while data is valid.
// R14: Write, refresh and chip select inputs define the command at rising edge.
// R15: Controller holds chip select high when it issues no command.
`include "dpc_cfg.svh"
`timescale 1ns/100ps

module dpc_pin_capture (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Organisation strap
	input wire logic [1:0] org_i,
	// Command pins
	input wire logic ck_i,
	input wire logic cs_b_i,
	input wire logic we_b_i,
	input wire logic ref_b_i,
	input wire logic [`DPC_ADDR_W-1:0] addr_i,
	input wire logic [`DPC_BANK_W-1:0] bank_select_i,
	// Write data pins
	input wire logic write_clock_lower_half_i,
	input wire logic write_clock_upper_half_i,
	input wire logic write_beat_mask_i,
	// Data bus pins
	input wire logic [`DPC_DQ_W-1:0] dq_i,
	output logic [`DPC_DQ_W-1:0] dq_o,
	output logic dq_oe_o,
	output logic [1:0] read_data_output_clock_o,
	output logic read_data_valid_o,
	// Decoded command to core
	output logic cmd_valid_o,
	output dpc_pkg::dpc_cmd_t cmd_o,
	output logic [`DPC_BANK_W-1:0] cmd_bank_o,
	output logic [`DPC_ADDR_W-1:0] cmd_addr_o,
	output logic [`DPC_ADDR_W-1:0] mode_register_set_cmd_o,
	output logic mode_load_o,
	// Write data to core
	output logic wr_valid_o,
	input wire logic wr_ready_i,
	output logic [`DPC_DQ_W-1:0] wr_data_o,
	output logic wr_drop_o,
	// Read data from core
	input wire logic rd_valid_i,
	output logic rd_ready_o,
	input wire logic [`DPC_DQ_W-1:0] rd_data_i
);
	import dpc_pkg::*;

	dpc_state_t s_reg;
	dpc_state_t s_next;
	logic push_valid;
	logic push_ready;
	logic [`DPC_DQ_W-1:0] push_data;

	// Register values while reset is held; command stage idles deselected
	localparam dpc_state_t RESET_STATE = '{
		// Pin synchronisers
		cmd_s0: `DPC_CMD_IDLE,
		cmd_s1: `DPC_CMD_IDLE,
		ck_s0: 1'b0,
		ck_s1: 1'b0,
		ck_prev: 1'b0,
		wk_s0: 2'h0,
		wk_s1: 2'h0,
		wk_prev: 2'h0,
		dm_s0: 1'b0,
		dm_s1: 1'b0,
		dq_s0: '0,
		dq_s1: '0,
		// Command side
		org: ORG_X9,
		org_done: 1'b0,
		cmd_valid: 1'b0,
		cmd: CMD_NOP,
		bank: '0,
		addr: '0,
		mode_reg: '0,
		mode_load: 1'b0,
		// Write side
		beats_left: 4'h0,
		lo_hold: '0,
		drop: 1'b0,
		// Read side
		qk_cnt: 3'h0,
		qk: 1'b0,
		rd_hold: '0,
		rd_hold_v: 1'b0,
		dq_out: '0,
		read_data_valid: 1'b0
	};

	// Active data lanes for an organisation
	function automatic logic [`DPC_DQ_W-1:0] lane_mask(input dpc_org_t org);
		logic [`DPC_DQ_W-1:0] m;
		m = '0;
		case (org)
			ORG_X9: m[`DPC_X9_W-1:0] = '1;
			ORG_X18: m[`DPC_HALF_W-1:0] = '1;
			default: m = '1;
		endcase
		return m;
	endfunction

	// Command from write and refresh inputs
	function automatic dpc_cmd_t decode_cmd(input logic we_b, input logic ref_b);
		dpc_cmd_t c;
		c = CMD_NOP;
		case ({we_b, ref_b})
			2'h0: c = CMD_MRS;
			2'h1: c = CMD_WRITE;
			2'h2: c = CMD_REF;
			default: c = CMD_READ;
		endcase
		return c;
	endfunction

	// Strap decode
	function automatic dpc_org_t decode_org(input logic [1:0] code);
		dpc_org_t o;
		o = ORG_X36;
		if (code == `DPC_ORG_CODE_X9) begin
			o = ORG_X9;
		end else if (code == `DPC_ORG_CODE_X18) begin
			o = ORG_X18;
		end
		return o;
	endfunction

	always_comb begin
		logic ck_rise;
		logic [1:0] wk_edge;
		logic cs_b;
		logic we_b;
		logic ref_b;
		logic [`DPC_BANK_W-1:0] bank;
		logic [`DPC_ADDR_W-1:0] addr;
		logic beat_edge;
		logic [`DPC_DQ_W-1:0] beat;
		cs_b = s_reg.cmd_s1[`DPC_CMD_CS_POS];
		we_b = s_reg.cmd_s1[`DPC_CMD_WE_POS];
		ref_b = s_reg.cmd_s1[`DPC_CMD_REF_POS];
		bank = s_reg.cmd_s1[`DPC_CMD_BANK_LSB +: `DPC_BANK_W];
		addr = s_reg.cmd_s1[`DPC_ADDR_W-1:0];
		ck_rise = 1'b0;
		wk_edge = 2'h0;
		beat_edge = 1'b0;
		beat = '0;
		s_next = s_reg;
		push_valid = 1'b0;
		push_data = '0;

		// Two-flop synchronisers on every pin except the organisation strap
		s_next.cmd_s0 = {cs_b_i, we_b_i, ref_b_i, bank_select_i, addr_i};
		s_next.cmd_s1 = s_reg.cmd_s0;
		s_next.ck_s0 = ck_i;
		s_next.ck_s1 = s_reg.ck_s0;
		s_next.ck_prev = s_reg.ck_s1;
		s_next.wk_s0 = {write_clock_upper_half_i, write_clock_lower_half_i};
		s_next.wk_s1 = s_reg.wk_s0;
		s_next.wk_prev = s_reg.wk_s1;
		s_next.dm_s0 = write_beat_mask_i;
		s_next.dm_s1 = s_reg.dm_s0;
		s_next.dq_s0 = dq_i;
		s_next.dq_s1 = s_reg.dq_s0;

		// Strap caught once after reset release
		if (!s_reg.org_done) begin
			s_next.org = decode_org(org_i);
			s_next.org_done = 1'b1;
		end

		// Command decode on rising input clock
		ck_rise = s_reg.ck_s1 & ~s_reg.ck_prev; // [R1]
		s_next.cmd_valid = 1'b0;
		s_next.mode_load = 1'b0;
		if (ck_rise && !cs_b) begin // [R2] [R3]
			s_next.cmd_valid = 1'b1;
			s_next.cmd = decode_cmd(we_b, ref_b); // [R14]
			s_next.bank = bank; // [R6]
			s_next.addr = addr; // [R4]
			case (decode_cmd(we_b, ref_b))
				CMD_MRS: begin
					s_next.mode_reg = addr; // [R5]
					s_next.mode_load = 1'b1;
				end
				CMD_WRITE: begin
					s_next.beats_left = `DPC_BURST_BEATS;
				end
				default: begin
				end
			endcase
		end

		// Write beats on both edges of the write clocks
		wk_edge = s_reg.wk_s1 ^ s_reg.wk_prev; // [R7]
		if (s_reg.org == ORG_X36) begin
			if (wk_edge[0]) begin
				s_next.lo_hold = s_reg.dq_s1[`DPC_HALF_W-1:0];
			end
			beat_edge = wk_edge[1]; // [R9] [R12]
			beat = {s_reg.dq_s1[`DPC_DQ_W-1:`DPC_HALF_W],
				wk_edge[0] ? s_reg.dq_s1[`DPC_HALF_W-1:0] : s_reg.lo_hold}; // [R9]
		end else begin
			beat_edge = wk_edge[0]; // [R10]
			beat = s_reg.dq_s1 & lane_mask(s_reg.org);
		end

		// Burst runs on whatever chip select does
		s_next.drop = 1'b0;
		if (beat_edge && s_reg.beats_left != 4'h0) begin // [R3]
			s_next.beats_left = s_reg.beats_left - 4'h1;
			if (!s_reg.dm_s1) begin // [R12]
				push_valid = 1'b1;
				push_data = beat;
				s_next.drop = ~push_ready;
			end
		end

		// Free-running output data clock
		if (s_reg.qk_cnt == 3'(`DPC_QK_HALF_CYC - 1)) begin
			s_next.qk_cnt = 3'h0;
			s_next.qk = ~s_reg.qk;
			if (s_reg.rd_hold_v) begin // [R8]
				s_next.dq_out = s_reg.rd_hold & lane_mask(s_reg.org);
				s_next.read_data_valid = 1'b1; // [R13]
				s_next.rd_hold_v = 1'b0;
			end else begin
				s_next.read_data_valid = 1'b0; // [R13]
				s_next.dq_out = '0;
			end
		end else begin
			s_next.qk_cnt = s_reg.qk_cnt + 3'h1;
		end

		// Read beat taken from core
		if (rd_valid_i && !s_reg.rd_hold_v) begin
			s_next.rd_hold = rd_data_i;
			s_next.rd_hold_v = 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_reg <= RESET_STATE;
		end else begin
			s_reg <= s_next;
		end
	end

	dpc_fifo #(
		.W(`DPC_FIFO_W),
		.D(`DPC_FIFO_DEPTH)
	) u_wr_fifo (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.in_valid_i(push_valid),
		.in_ready_o(push_ready),
		.in_data_i(push_data),
		.out_valid_o(wr_valid_o),
		.out_ready_i(wr_ready_i),
		.out_data_o(wr_data_o)
	);

	assign dq_o = s_reg.dq_out;
	assign dq_oe_o = s_reg.read_data_valid;
	// One output clock per data half
	for (genvar g = 0; g < 2; g++) begin : g_qk_pair
		assign read_data_output_clock_o[g] = s_reg.qk; // [R8]
	end
	assign read_data_valid_o = s_reg.read_data_valid;
	assign cmd_valid_o = s_reg.cmd_valid;
	assign cmd_o = s_reg.cmd;
	assign cmd_bank_o = s_reg.bank;
	assign cmd_addr_o = s_reg.addr;
	assign mode_register_set_cmd_o = s_reg.mode_reg;
	assign mode_load_o = s_reg.mode_load;
	assign wr_drop_o = s_reg.drop;
	assign rd_ready_o = ~s_reg.rd_hold_v;

endmodule // dpc_pin_capture

// File: rtl/dpc_pkg.sv
// Types for the DDR pin capture block
`include "dpc_cfg.svh"

package dpc_pkg;

	typedef enum logic [1:0] {ORG_X9, ORG_X18, ORG_X36} dpc_org_t;

	typedef enum logic [2:0] {CMD_NOP, CMD_READ, CMD_WRITE, CMD_REF, CMD_MRS} dpc_cmd_t;

	typedef struct packed {
		logic [`DPC_CMD_BUS_W-1:0] cmd_s0;
		logic [`DPC_CMD_BUS_W-1:0] cmd_s1;
		logic ck_s0;
		logic ck_s1;
		logic ck_prev;
		logic [1:0] wk_s0;
		logic [1:0] wk_s1;
		logic [1:0] wk_prev;
		logic dm_s0;
		logic dm_s1;
		logic [`DPC_DQ_W-1:0] dq_s0;
		logic [`DPC_DQ_W-1:0] dq_s1;
		dpc_org_t org;
		logic org_done;
		logic cmd_valid;
		dpc_cmd_t cmd;
		logic [`DPC_BANK_W-1:0] bank;
		logic [`DPC_ADDR_W-1:0] addr;
		logic [`DPC_ADDR_W-1:0] mode_reg;
		logic mode_load;
		logic [3:0] beats_left;
		logic [`DPC_HALF_W-1:0] lo_hold;
		logic drop;
		logic [2:0] qk_cnt;
		logic qk;
		logic [`DPC_DQ_W-1:0] rd_hold;
		logic rd_hold_v;
		logic [`DPC_DQ_W-1:0] dq_out;
		logic read_data_valid;
	} dpc_state_t;

endpackage

// File: sim/dpc_host_model.sv
// Host controller model driving command and write pins
`timescale 1ns/100ps
module dpc_host_model (
	input wire logic clk_i,
	output logic ck_o,
	output logic cs_b_o,
	output logic we_b_o,
	output logic ref_b_o,
	output logic [20:0] addr_o,
	output logic [2:0] bank_o,
	output logic wclk_lo_o,
	output logic wclk_hi_o,
	output logic mask_o,
	output logic [35:0] dq_o
);
	initial begin
		{cs_b_o, we_b_o, ref_b_o} = 3'h7;
		{addr_o, bank_o, wclk_lo_o, wclk_hi_o, mask_o, dq_o} = '0;
		ck_o = 1'b0;
		forever #200 ck_o = ~ck_o;
	end
	task automatic issue(input logic cs_b, input logic [1:0] wr, input logic [20:0] a,
		input logic [2:0] b);
		@(negedge ck_o);
		@(posedge clk_i);
		cs_b_o <= cs_b;
		{we_b_o, ref_b_o} <= wr;
		addr_o <= a;
		bank_o <= b;
		@(negedge ck_o);
		@(posedge clk_i);
		cs_b_o <= 1'b1;
		addr_o <= ~a;
	endtask
	task automatic beat(input logic [35:0] d, input logic m);
		@(posedge clk_i);
		dq_o <= d;
		mask_o <= m;
		repeat (3) @(posedge clk_i);
		wclk_lo_o <= ~wclk_lo_o;
		wclk_hi_o <= ~wclk_hi_o;
		repeat (3) @(posedge clk_i);
		dq_o <= ~d;
		mask_o <= ~m;
	endtask
endmodule // dpc_host_model

// File: sim/dpc_pin_capture_assertions.sv
// Port checker for the pin capture block
`timescale 1ns/100ps
`include "dpc_cfg.svh"
module dpc_pin_capture_chk import dpc_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic rd_valid_i,
	input wire logic rd_ready_o,
	input wire logic wr_ready_i,
	input wire logic wr_valid_o,
	input wire logic [`DPC_DQ_W-1:0] wr_data_o,
	input wire logic cmd_valid_o,
	input wire dpc_cmd_t cmd_o,
	input wire logic [`DPC_BANK_W-1:0] cmd_bank_o,
	input wire logic [`DPC_ADDR_W-1:0] cmd_addr_o,
	input wire logic [`DPC_ADDR_W-1:0] mode_register_set_cmd_o,
	input wire logic mode_load_o,
	input wire logic dq_oe_o,
	input wire logic read_data_valid_o,
	input wire logic [1:0] read_data_output_clock_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);
	sequence qk_flip;
		$changed(read_data_output_clock_o[0]);
	endsequence
	a_cmd_one_pulse: assert property (cmd_valid_o |=> !cmd_valid_o)
		else $error("command pulse too long");
	a_mode_from_addr: assert property (mode_load_o |-> cmd_valid_o && cmd_o == CMD_MRS
		&& mode_register_set_cmd_o == cmd_addr_o) else $error("mode load mismatch");
	a_bank_held: assert property (!cmd_valid_o |-> $stable(cmd_bank_o)
		&& $stable(cmd_addr_o)) else $error("bank or address moved");
	a_oe_is_valid: assert property (dq_oe_o == read_data_valid_o)
		else $error("enable differs from valid");
	a_valid_aligned: assert property ($changed(read_data_valid_o) |-> qk_flip)
		else $error("valid not on clock edge");
	a_qk_half: assert property (qk_flip |=> $stable(read_data_output_clock_o)[*3] ##1 qk_flip)
		else $error("output clock period wrong");
	a_qk_pair: assert property (read_data_output_clock_o[0] == read_data_output_clock_o[1])
		else $error("output clocks differ");
	a_read_answer: assert property (rd_valid_i && rd_ready_o |->
		##[2:5] ($changed(read_data_output_clock_o[0]) && read_data_valid_o))
		else $error("read beat not sent");
	a_write_head: assert property (wr_valid_o && !wr_ready_i |=> wr_valid_o
		&& $stable(wr_data_o)) else $error("write head lost");
endmodule // dpc_pin_capture_chk
bind dpc_pin_capture dpc_pin_capture_chk chk (
	.clk_i(clk_i), .rst_b_i(rst_b_i), .rd_valid_i(rd_valid_i), .rd_ready_o(rd_ready_o),
	.wr_ready_i(wr_ready_i), .wr_valid_o(wr_valid_o), .wr_data_o(wr_data_o),
	.cmd_valid_o(cmd_valid_o), .cmd_o(cmd_o), .cmd_bank_o(cmd_bank_o),
	.cmd_addr_o(cmd_addr_o), .mode_register_set_cmd_o(mode_register_set_cmd_o),
	.mode_load_o(mode_load_o), .dq_oe_o(dq_oe_o), .read_data_valid_o(read_data_valid_o),
	.read_data_output_clock_o(read_data_output_clock_o)
);

// File: sim/tb_top.sv
// Self-checking bench for the pin capture block
`timescale 1ns/100ps
`include "dpc_cfg.svh"
module tb_top;
	import dpc_pkg::*;
	logic clk_i, rst_b_i, ck_i, cs_b_i, we_b_i, ref_b_i, wr_ready_i, rd_valid_i;
	logic write_clock_lower_half_i, write_clock_upper_half_i, write_beat_mask_i;
	logic dq_oe_o, read_data_valid_o, cmd_valid_o, mode_load_o, wr_valid_o, wr_drop_o, rd_ready_o;
	logic [1:0] org_i, read_data_output_clock_o;
	logic [20:0] addr_i, cmd_addr_o, mode_register_set_cmd_o;
	logic [2:0] bank_select_i, cmd_bank_o;
	logic [35:0] dq_i, dq_o, wr_data_o, rd_data_i;
	dpc_cmd_t cmd_o;
	int failures, tests_run, ncv, ndrop, cyc;
	dpc_pin_capture uut (
		.clk_i(clk_i), .rst_b_i(rst_b_i), .org_i(org_i), .ck_i(ck_i), .cs_b_i(cs_b_i),
		.we_b_i(we_b_i), .ref_b_i(ref_b_i), .addr_i(addr_i), .bank_select_i(bank_select_i),
		.write_clock_lower_half_i(write_clock_lower_half_i),
		.write_clock_upper_half_i(write_clock_upper_half_i),
		.write_beat_mask_i(write_beat_mask_i), .dq_i(dq_i), .dq_o(dq_o), .dq_oe_o(dq_oe_o),
		.read_data_output_clock_o(read_data_output_clock_o),
		.read_data_valid_o(read_data_valid_o), .cmd_valid_o(cmd_valid_o), .cmd_o(cmd_o),
		.cmd_bank_o(cmd_bank_o), .cmd_addr_o(cmd_addr_o),
		.mode_register_set_cmd_o(mode_register_set_cmd_o), .mode_load_o(mode_load_o),
		.wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready_i), .wr_data_o(wr_data_o),
		.wr_drop_o(wr_drop_o), .rd_valid_i(rd_valid_i), .rd_ready_o(rd_ready_o),
		.rd_data_i(rd_data_i)
	);
	dpc_host_model host (.clk_i(clk_i), .ck_o(ck_i), .cs_b_o(cs_b_i), .we_b_o(we_b_i),
		.ref_b_o(ref_b_i), .addr_o(addr_i), .bank_o(bank_select_i),
		.wclk_lo_o(write_clock_lower_half_i), .wclk_hi_o(write_clock_upper_half_i),
		.mask_o(write_beat_mask_i), .dq_o(dq_i));
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		ncv += (cmd_valid_o === 1'b1);
		ndrop += (wr_drop_o === 1'b1);
		cyc++;
		if (cyc == 6000) begin
			failures++;
			complete_run();
		end
	end
	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic complete_run();
		$display("failures=%0d tests_run=%0d", failures, tests_run);
		if (failures == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic do_reset(input logic [1:0] o);
		org_i <= o;
		rst_b_i <= 1'b0;
		repeat (6) @(posedge clk_i);
		rst_b_i <= 1'b1;
		repeat (2) @(posedge clk_i);
	endtask
	task automatic pop();
		@(posedge clk_i);
		wr_ready_i <= 1'b1;
		@(posedge clk_i);
		wr_ready_i <= 1'b0;
		@(negedge clk_i);
	endtask
	task automatic t_cmds();
		dpc_cmd_t exp[4];
		int n0;
		exp = '{CMD_MRS, CMD_WRITE, CMD_REF, CMD_READ};
		for (int i = 0; i < 4; i++) begin
			n0 = ncv;
			host.issue(1'b0, i[1:0], 21'h155555 ^ 21'(i), 3'(7 - i));
			if (i == 1) begin
				host.beat(36'h1_2345_6789, 1'b1);
				host.beat(36'h2_3456_789A, 1'b1);
			end
			repeat (4) @(posedge clk_i);
			chk(36'(ncv - n0), 36'h1);
			chk(36'(cmd_o), 36'(exp[i]));
			chk(36'(cmd_bank_o), 36'(7 - i));
			chk(36'(cmd_addr_o), 36'(21'h155555 ^ 21'(i)));
		end
		chk(36'(mode_register_set_cmd_o), 36'h155555);
		chk(36'(wr_valid_o), 36'h0);
	endtask
	task automatic t_cs_burst();
		int n0;
		host.issue(1'b0, 2'h1, 21'h0, 3'h5);
		host.beat(36'hA_BCDE_F012, 1'b0);
		n0 = ncv;
		host.issue(1'b1, 2'h3, 21'h0AAAAA, 3'h2);
		host.beat(36'h3_0405_0607, 1'b0);
		repeat (4) @(posedge clk_i);
		chk(36'(ncv - n0), 36'h0);
		chk(36'(cmd_bank_o), 36'h5);
		chk(wr_data_o, 36'hA_BCDE_F012);
		pop();
		chk(wr_data_o, 36'h3_0405_0607);
		pop();
		@(posedge clk_i);
		chk(36'(wr_valid_o), 36'h0);
	endtask
	task automatic t_fill();
		int d0;
		d0 = ndrop;
		for (int j = 0; j < 9; j++) begin
			host.issue(1'b0, 2'h1, 21'(j), 3'(j));
			host.beat(36'h8_0000_0000 + 36'(2 * j), 1'b0);
			host.beat(36'h8_0000_0001 + 36'(2 * j), 1'b0);
		end
		repeat (3) @(posedge clk_i);
		chk(36'(ndrop - d0), 36'h2);
		for (int k = 0; k < 16; k++) begin
			chk(wr_data_o, 36'h8_0000_0000 + 36'(k));
			pop();
		end
		@(posedge clk_i);
		chk(36'(wr_valid_o), 36'h0);
	endtask
	task automatic t_read(input logic [35:0] m);
		int n;
		@(posedge clk_i);
		chk(36'(rd_ready_o), 36'h1);
		rd_valid_i <= 1'b1;
		rd_data_i <= 36'h9_8765_4321;
		@(posedge clk_i);
		rd_valid_i <= 1'b0;
		@(negedge clk_i);
		chk(36'(rd_ready_o), 36'h0);
		for (n = 0; n < 8 && read_data_valid_o !== 1'b1; n++)
			@(posedge clk_i);
		chk(36'(rd_ready_o), 36'h1);
		chk(dq_o, 36'h9_8765_4321 & m);
		chk(36'(dq_oe_o), 36'h1);
		for (n = 0; n < 10 && read_data_valid_o === 1'b1; n++)
			@(posedge clk_i);
		chk(36'(n), 36'h4);
	endtask
	task automatic t_x9();
		do_reset(2'h0);
		host.issue(1'b0, 2'h1, 21'h0, 3'h0);
		host.beat(36'hF_FFFF_FE5A, 1'b0);
		host.beat(36'hF_FFFF_FFFF, 1'b1);
		repeat (4) @(posedge clk_i);
		chk(wr_data_o, 36'h05A);
		pop();
		t_read(36'h1FF);
	endtask
	task automatic t_x18();
		do_reset(2'h1);
		host.issue(1'b0, 2'h1, 21'h0, 3'h1);
		host.beat(36'hF_FFFF_FE5A, 1'b0);
		host.beat(36'h0_0000_0000, 1'b1);
		repeat (4) @(posedge clk_i);
		chk(wr_data_o, 36'h0_0003_FE5A);
		pop();
		t_read(36'h0_0003_FFFF);
	endtask
	initial begin
		{rst_b_i, wr_ready_i, rd_valid_i, org_i, rd_data_i} = '0;
		do_reset(2'h2);
		t_cmds();
		t_cs_burst();
		t_fill();
		t_read(36'hF_FFFF_FFFF);
		t_x9();
		t_x18();
		complete_run();
	end
endmodule // tb_top
